// >>> shared/tpr_pkg.sv
`default_nettype none

package tpr_pkg;

  // Result codes and steps
  localparam logic [7:0] CODE_BUS_RESET = 8'h01;
  localparam logic [7:0] CODE_PARITY    = 8'h24;
  localparam logic [7:0] CODE_TIMEOUT   = 8'h2c;
  localparam logic [7:0] CODE_DONE      = 8'h60;
  localparam logic [7:0] CODE_ATN       = 8'h61;
  localparam logic [7:0] CODE_ATN_MSG   = 8'h62;
  localparam logic [7:0] CODE_MSG_LONG  = 8'h64;
  localparam logic [7:0] CODE_BAD_GROUP = 8'h65;
  localparam logic [7:0] CODE_RX_LONG   = 8'h67;
  localparam logic [7:0] STEP_BEFORE    = 8'h00;
  localparam logic [7:0] STEP_DURING    = 8'h01;
  localparam logic [7:0] STEP_AFTER     = 8'h02;

  // Message length limits
  localparam logic [5:0] MSG_LEN_LIMIT  = 6'h21;
  localparam logic [7:0] EXT_LEN_LIMIT  = 8'h1f;
  localparam logic [7:0] EXT_MSG_FIRST  = 8'h01;
  localparam logic [3:0] TWO_BYTE_HI    = 4'h2;
  localparam logic [5:0] EXT_LEN_OPEN   = 6'h3f;
  localparam logic [5:0] EXT_LEN_HDR    = 6'h02;

  // Command group lengths
  localparam logic [5:0] GRP0_LEN       = 6'h06;
  localparam logic [5:0] GRP12_LEN      = 6'h0a;
  localparam logic [5:0] GRP5_LEN       = 6'h0c;

  // Receive FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // Reset values
  localparam logic [15:0] TMO_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    CMD_SEND_MSG    = 2'b00,
    CMD_RECV_MSG    = 2'b01,
    CMD_SEND_STATUS = 2'b10,
    CMD_RECV_CMD    = 2'b11
  } tpr_cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_POST = 2'b10
  } tpr_state_e;

endpackage

`default_nettype wire

// >>> design/tpr_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module tpr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]   wr;
    logic [AW:0]   rd;
  } tpr_fifo_s;

  tpr_fifo_s             s_q;
  tpr_fifo_s             s_d;
  logic      [WIDTH-1:0] mem [DEPTH];
  logic                  push;
  logic                  pop;

  assign in_ready  = (s_q.wr - s_q.rd) != (AW+1)'(DEPTH);
  assign out_valid = s_q.wr != s_q.rd;
  assign out_data  = mem[s_q.rd[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    if (push) begin
      mem[s_q.wr[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

// >>> design/tpr_reporter.sv
`timescale 1ns/10ps
`default_nettype none

module tpr_reporter (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        cmd_start,
  input  wire logic [1:0]  cmd_sel,
  input  wire logic [5:0]  msg_len,
  input  wire logic        auto_receive,
  input  wire logic [15:0] req_ack_timeout,
  output logic             cmd_busy,
  input  wire logic [7:0]  host_tx_data,
  input  wire logic        host_tx_valid,
  output logic             host_tx_ready,
  output logic      [7:0]  host_rx_data,
  output logic             host_rx_valid,
  input  wire logic        host_rx_ready,
  input  wire logic        bus_reset,
  input  wire logic        bus_atn,
  output logic      [7:0]  link_tx_data,
  output logic             link_tx_valid,
  input  wire logic        link_tx_ready,
  input  wire logic [7:0]  link_rx_data,
  input  wire logic        link_rx_parity_err,
  input  wire logic        link_rx_valid,
  output logic             link_rx_ready,
  output logic      [7:0]  result_code,
  output logic      [7:0]  result_step,
  output logic             result_irq,
  input  wire logic        result_ack
);

  typedef struct packed {
    tpr_pkg::tpr_state_e state;
    tpr_pkg::tpr_cmd_e   cmd;
    logic                auto_rx;
    logic [5:0]          cnt;
    logic [5:0]          len;
    logic [7:0]          first;
    logic [15:0]         tmo;
    logic [7:0]          tx_byte;
    logic                tx_full;
    logic [7:0]          code;
    logic [7:0]          step;
    logic                irq;
  } tpr_s;

  tpr_s        s_q;
  tpr_s        s_d;
  logic        fifo_in_ready;
  logic        fifo_in_valid;
  logic        sending;
  logic        receiving;
  logic        rx_take;
  logic        tx_load;
  logic [5:0]  nb;
  logic [2:0]  grp;

  assign sending   = (s_q.state == tpr_pkg::ST_XFER) && !s_q.auto_rx &&
                     !s_q.cmd[0];
  assign receiving = (s_q.state == tpr_pkg::ST_XFER) &&
                     (s_q.auto_rx || s_q.cmd[0]);
  assign tx_load   = sending && !s_q.tx_full && !bus_reset;
  assign link_rx_ready = receiving && fifo_in_ready && !bus_reset;
  assign rx_take   = link_rx_valid && link_rx_ready;
  assign host_tx_ready = tx_load;
  assign fifo_in_valid = rx_take && !link_rx_parity_err;
  assign nb        = s_q.cnt + 6'h01;
  assign grp       = link_rx_data[7:5];

  assign cmd_busy      = s_q.state != tpr_pkg::ST_IDLE;
  assign link_tx_data  = s_q.tx_byte;
  assign link_tx_valid = s_q.tx_full;
  assign result_code   = s_q.code;
  assign result_step   = s_q.step;
  assign result_irq    = s_q.irq;

  tpr_fifo #(
    .WIDTH (tpr_pkg::FIFO_WIDTH),
    .DEPTH (tpr_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   (link_rx_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (host_rx_data),
    .out_valid (host_rx_valid),
    .out_ready (host_rx_ready)
  );

  // Posts a result and returns to idle
  function automatic tpr_s post(input tpr_s s, input logic [7:0] code,
                                input logic [7:0] step);
    tpr_s r;
    r         = s;
    r.code    = code;
    r.step    = step;
    r.irq     = 1'b1;
    r.state   = tpr_pkg::ST_IDLE;
    r.tx_full = 1'b0;
    r.auto_rx = 1'b0;
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    if (result_ack) begin
      s_d.irq = 1'b0;
    end
    unique case (s_q.state)
      tpr_pkg::ST_IDLE: begin
        if (cmd_start) begin
          s_d.cmd     = tpr_pkg::tpr_cmd_e'(cmd_sel);
          s_d.cnt     = '0;
          s_d.tmo     = tpr_pkg::TMO_RESET;
          s_d.auto_rx = 1'b0;
          s_d.len     = (cmd_sel == tpr_pkg::CMD_SEND_STATUS) ?
                        6'h01 : msg_len;
          if (bus_reset) begin
            s_d = post(s_d, tpr_pkg::CODE_BUS_RESET,
                       tpr_pkg::STEP_BEFORE);
          end else if (cmd_sel == tpr_pkg::CMD_SEND_MSG &&
                       msg_len >= tpr_pkg::MSG_LEN_LIMIT) begin
            s_d = post(s_d, tpr_pkg::CODE_MSG_LONG,
                       tpr_pkg::STEP_DURING);
          end else begin
            s_d.state = tpr_pkg::ST_XFER;
          end
        end
      end
      tpr_pkg::ST_XFER: begin
        s_d.tmo = s_q.tmo + 16'h0001;
        if (bus_reset) begin
          s_d = post(s_d, tpr_pkg::CODE_BUS_RESET,
                     tpr_pkg::STEP_DURING);
        end else if (req_ack_timeout != '0 &&
                     s_q.tmo >= req_ack_timeout) begin
          s_d = post(s_d, tpr_pkg::CODE_TIMEOUT,
                     tpr_pkg::STEP_DURING);
        end else if (sending) begin
          if (tx_load && host_tx_valid) begin
            s_d.tx_byte = host_tx_data;
            s_d.tx_full = 1'b1;
            s_d.tmo     = tpr_pkg::TMO_RESET;
          end else if (s_q.tx_full && link_tx_ready) begin
            s_d.tx_full = 1'b0;
            s_d.tmo     = tpr_pkg::TMO_RESET;
            s_d.cnt     = nb;
            if (nb >= s_q.len) begin
              s_d.state = tpr_pkg::ST_POST;
            end
          end
        end else if (rx_take) begin
          s_d.tmo = tpr_pkg::TMO_RESET;
          s_d.cnt = nb;
          if (link_rx_parity_err) begin
            s_d = post(s_d, tpr_pkg::CODE_PARITY,
                       tpr_pkg::STEP_DURING);
          end else if (s_q.cmd == tpr_pkg::CMD_RECV_CMD && !s_q.auto_rx) begin
            if (s_q.cnt == '0) begin
              unique case (grp)
                3'd0: s_d.len = tpr_pkg::GRP0_LEN;
                3'd1, 3'd2: s_d.len = tpr_pkg::GRP12_LEN;
                3'd5: s_d.len = tpr_pkg::GRP5_LEN;
                3'd3, 3'd4, 3'd6, 3'd7: begin
                  s_d = post(s_d, tpr_pkg::CODE_BAD_GROUP,
                             tpr_pkg::STEP_DURING);
                end
              endcase
            end else if (nb >= s_q.len) begin
              s_d.state = tpr_pkg::ST_POST;
            end
          end else begin
            if (s_q.cnt == '0) begin
              s_d.first = link_rx_data;
              if (link_rx_data == tpr_pkg::EXT_MSG_FIRST) begin
                s_d.len = tpr_pkg::EXT_LEN_OPEN;
              end else if (link_rx_data[7:4] == tpr_pkg::TWO_BYTE_HI) begin
                s_d.len = 6'h02;
              end else begin
                s_d.len = 6'h01;
                s_d.state = tpr_pkg::ST_POST;
              end
            end else if (s_q.cnt == 6'h01 &&
                         s_q.first == tpr_pkg::EXT_MSG_FIRST) begin
              if (link_rx_data >= tpr_pkg::EXT_LEN_LIMIT) begin
                s_d = post(s_d, tpr_pkg::CODE_RX_LONG,
                           tpr_pkg::STEP_DURING);
              end else begin
                s_d.len = link_rx_data[5:0] + tpr_pkg::EXT_LEN_HDR;
              end
            end else if (nb >= s_q.len) begin
              s_d.state = tpr_pkg::ST_POST;
            end
          end
        end
      end
      tpr_pkg::ST_POST: begin
        if (bus_reset) begin
          s_d = post(s_d, tpr_pkg::CODE_BUS_RESET,
                     tpr_pkg::STEP_AFTER);
        end else if (s_q.auto_rx) begin
          s_d = post(s_d, tpr_pkg::CODE_ATN_MSG,
                     tpr_pkg::STEP_AFTER);
        end else if (bus_atn && !auto_receive) begin
          s_d = post(s_d, tpr_pkg::CODE_ATN,
                     tpr_pkg::STEP_AFTER);
        end else if (bus_atn && s_q.cmd != tpr_pkg::CMD_RECV_MSG) begin
          s_d.auto_rx = 1'b1;
          s_d.cnt     = '0;
          s_d.tmo     = tpr_pkg::TMO_RESET;
          s_d.state   = tpr_pkg::ST_XFER;
        end else begin
          s_d = post(s_d, tpr_pkg::CODE_DONE,
                     tpr_pkg::STEP_AFTER);
        end
      end
      default: begin
        s_d.state = tpr_pkg::ST_IDLE;
      end
    endcase
    if (s_q.irq && !result_ack) begin
      s_d.irq = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q       <= '0;
      s_q.state <= tpr_pkg::ST_IDLE;
      s_q.cmd   <= tpr_pkg::CMD_SEND_MSG;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

// >>> sim/tpr_props.sv
`timescale 1ns/10ps
`default_nettype none
module tpr_props (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       cmd_start,
  input wire logic [1:0] cmd_sel,
  input wire logic [5:0] msg_len,
  input wire logic       cmd_busy,
  input wire logic       bus_reset,
  input wire logic       link_tx_valid,
  input wire logic       link_rx_ready,
  input wire logic [7:0] result_code,
  input wire logic [7:0] result_step,
  input wire logic       result_irq,
  input wire logic       result_ack
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_irq_hold: assert property (
    result_irq && !result_ack |=> result_irq) else $error("irq lost");
  a_result_hold: assert property (
    !cmd_busy && !cmd_start |=> $stable(result_code) && $stable(result_step))
    else $error("result moved while idle");
  a_post_idle: assert property (
    $rose(result_irq) |-> !cmd_busy) else $error("irq while busy");
  a_err_step: assert property (
    $rose(result_irq) && result_code inside {8'h24, 8'h2c, 8'h64, 8'h65,
    8'h67} |-> result_step == 8'h01) else $error("error step wrong");
  a_done_step: assert property (
    $rose(result_irq) && result_code inside {8'h60, 8'h61, 8'h62}
    |-> result_step == 8'h02) else $error("done step wrong");
  a_long_msg: assert property (
    cmd_start && !cmd_busy && !bus_reset && cmd_sel == 2'h0
    && msg_len >= 6'h21 |-> !link_tx_valid ##1 (!link_tx_valid
    && result_irq && result_code == 8'h64) ##1 !link_tx_valid [*2])
    else $error("long message");
  a_reset_first: assert property (
    cmd_start && !cmd_busy && bus_reset |-> ##[1:4] (result_irq
    && result_code == 8'h01 && result_step == 8'h00)) else $error("rst");
  a_idle_quiet: assert property (
    !cmd_busy |-> !link_tx_valid && !link_rx_ready)
    else $error("link active while idle");
endmodule
bind tpr_reporter tpr_props u_props (.*);
`default_nettype wire

// >>> sim/tpr_initiator.sv
`timescale 1ns/10ps
`default_nettype none
module tpr_initiator (
  input  wire logic       mclk,
  input  wire logic [1:0] pmode,
  input  wire logic [7:0] link_tx_data,
  input  wire logic       link_tx_valid,
  output logic            link_tx_ready,
  output logic      [7:0] link_rx_data,
  output logic            link_rx_valid,
  output logic            link_rx_parity_err,
  input  wire logic       link_rx_ready
);
  logic [8:0] rx_q[$];
  int         txn;
  logic       go;
  initial begin
    {link_tx_ready, link_rx_valid, link_rx_parity_err, link_rx_data} = '0;
    txn = 0;
  end
  // Mode 0 prompt, 1 slow, 2 stalled
  always @(posedge mclk) begin
    go = pmode == 2'h0 || (pmode == 2'h1 && $urandom_range(1) == 0);
    if (link_tx_valid && link_tx_ready)
      txn++;
    if (link_rx_valid && link_rx_ready)
      void'(rx_q.pop_front());
    link_tx_ready <= go;
    if (!(link_rx_valid && !link_rx_ready && rx_q.size() > 0)) begin
      link_rx_valid <= go && rx_q.size() > 0;
      {link_rx_parity_err, link_rx_data} <= (go && rx_q.size() > 0) ?
        rx_q[0] : ~{link_rx_parity_err, link_rx_data};
    end
  end
endmodule
`default_nettype wire

// >>> sim/tpr_reporter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tpr_reporter_tb_top;
  typedef struct {int sel, len, au, atn, md, rst, tmo, b0, b1, nb, pe;}
    tpr_row_s;
  logic        mclk, reset, cmd_start, auto_receive, bus_reset, bus_atn;
  logic        result_ack, drain, cmd_busy, host_tx_valid, host_tx_ready;
  logic        host_rx_valid, host_rx_ready, link_tx_valid, link_tx_ready;
  logic        link_rx_parity_err, link_rx_valid, link_rx_ready, result_irq;
  logic [1:0]  cmd_sel, pmode;
  logic [5:0]  msg_len;
  logic [15:0] req_ack_timeout;
  logic [7:0]  host_tx_data, host_rx_data, link_tx_data, link_rx_data;
  logic [7:0]  result_code, result_step;
  int          mismatches, compares, cyc, rxn;
  logic [7:0]  txq[$], rxq[$];
  tpr_row_s    t[14] = '{
    '{2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 99},
    '{0, 40, 0, 0, 0, 0, 0, 0, 0, 0, 99},
    '{0, 32, 0, 1, 1, 0, 0, 0, 0, 0, 99},
    '{2, 0, 1, 1, 0, 0, 0, 7, 0, 1, 99},
    '{1, 0, 0, 1, 0, 0, 0, 0, 0, 1, 99},
    '{1, 0, 0, 0, 1, 0, 0, 1, 32, 4, 99},
    '{3, 0, 0, 0, 0, 0, 0, 96, 0, 2, 99},
    '{3, 0, 0, 0, 1, 0, 0, 0, 0, 6, 2},
    '{3, 0, 0, 0, 0, 0, 0, 160, 0, 12, 99},
    '{2, 0, 0, 0, 2, 0, 20, 0, 0, 0, 99},
    '{2, 0, 0, 0, 2, 2, 0, 0, 0, 0, 99},
    '{2, 0, 0, 0, 0, 1, 0, 0, 0, 0, 99},
    '{2, 0, 0, 0, 1, 3, 0, 0, 0, 0, 99},
    '{1, 0, 1, 1, 0, 0, 0, 0, 0, 1, 99}};
  tpr_reporter u_dut (.*);
  tpr_initiator u_ini (.*);
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      test_done;
    end
    if (host_rx_valid && host_rx_ready) begin
      rxn++;
      cmp(host_rx_data, rxq.pop_front());
    end
    if (host_tx_valid && host_tx_ready) begin
      txq.push_back(host_tx_data);
      host_tx_data <= 8'($urandom);
    end
    if (link_tx_valid && link_tx_ready)
      cmp(link_tx_data, txq.pop_front());
    host_rx_ready <= drain && $urandom_range(1);
  end
  function automatic logic [15:0] ref_res(tpr_row_s r);
    if (r.rst != 0) return {8'h01, 8'(r.rst - 1)};
    if (r.md == 2) return 16'h2c01;
    if (r.sel == 0 && r.len >= 33) return 16'h6401;
    if (r.pe < r.nb) return 16'h2401;
    if (r.sel == 3 && (r.b0 >> 5) inside {3, 4, 6, 7}) return 16'h6501;
    if (r.sel == 1 && r.b0 == 1 && r.b1 >= 31) return 16'h6701;
    if (r.atn) return r.au ? (r.sel != 1 ? 16'h6202 : 16'h6002) : 16'h6102;
    return 16'h6002;
  endfunction
  task automatic cmp(logic [7:0] g, logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic run(int i);
    tpr_row_s r;
    logic [15:0] e;
    int n;
    logic [7:0] b;
    r = t[i];
    e = ref_res(r);
    n = 0;
    {cmd_sel, msg_len, pmode} = {2'(r.sel), 6'(r.len), 2'(r.md)};
    {auto_receive, bus_atn, bus_reset} = {r.au[0], r.atn[0], r.rst == 1};
    req_ack_timeout = 16'(r.tmo);
    u_ini.txn = 0;
    rxn = 0;
    rxq.delete();
    txq.delete();
    drain = r.nb <= 8;
    for (int k = 0; k < r.nb; k++) begin
      b = k == 0 ? 8'(r.b0) : k == 1 ? 8'(r.b1) : 8'($urandom);
      u_ini.rx_q.push_back({k == r.pe, b});
      if (k != r.pe)
        rxq.push_back(b);
    end
    cmd_start = 1;
    @(posedge mclk) #1 cmd_start = 0;
    if (r.rst == 2) repeat (10) @(posedge mclk);
    if (r.rst == 3)
      do @(negedge mclk); while (!(link_tx_valid && link_tx_ready));
    if (r.rst > 1) @(posedge mclk) #1 bus_reset = 1;
    if (r.nb > 8) begin
      repeat (40) @(posedge mclk);
      #1 cmp({7'h0, link_rx_ready}, 8'h00);
      drain = 1;
    end
    while (!result_irq && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (!result_irq) begin
      mismatches++;
      $display("[ERR] %0t no result posted", $time);
    end
    cmp(result_code, e[15:8]);
    cmp(result_step, e[7:0]);
    @(posedge mclk) #1 {bus_reset, result_ack, drain} = 3'b011;
    @(posedge mclk) #1 result_ack = 0;
    repeat (40) @(posedge mclk);
    #1 u_ini.rx_q.delete();
    @(posedge mclk) #1;
    if (r.rst == 0 && r.md != 2)
      cmp(8'(rxn), e[15:8] == 8'h67 ? 8'h02 :
          e[15:8] == 8'h65 ? 8'h01 : e[15:8] == 8'h24 ? 8'(r.pe) : 8'(r.nb));
    if (r.rst == 0 && r.md != 2 && r.sel[0] == 0)
      cmp(8'(u_ini.txn), e[15:8] == 8'h64 ? 8'h00 :
          r.len == 0 ? 8'h01 : 8'(r.len));
    $display("test %0d done", i);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {reset, host_tx_valid, cmd_start, auto_receive, bus_reset} = 5'b11000;
    {bus_atn, result_ack, drain, cmd_sel, pmode, msg_len} = '0;
    {req_ack_timeout, host_tx_data, host_rx_ready} = '0;
    {mismatches, compares, cyc, rxn} = '0;
    void'($urandom(48868));
    repeat (10) @(posedge mclk);
    #1 reset = 0;
    for (int i = 0; i < 14; i++)
      run(i);
    for (int g = 4; g < 8; g++) begin
      t[6].b0 = g == 5 ? 96 : g << 5;
      run(6);
    end
    test_done;
  end
endmodule
`default_nettype wire
